//--- hw/docu_top.sv
`timescale 1ns/1ns
`include "docu_map.svh"
module docu_top (
  // Clock and reset.
  input  wire logic               sys_clk,
  input  wire logic               srst,
  // APB slave.
  input  wire logic [15:0]        paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Refresh memory line operations.
  output logic                    memReq,
  output docu_pkg::docu_mem_t     memOp,
  input  wire logic               memAck,
  // Font ROM, one cycle read latency.
  output logic      [10:0]        promAddr,
  input  wire logic [7:0]         promData,
  // Illegal instruction event.
  output logic                    illegalInstr
);
  docu_pkg::docu_env_t   env;
  docu_pkg::docu_env_t   stack [0:4];
  docu_pkg::docu_state_t state;
  logic [2:0]  depth;
  logic        illSticky;
  logic        down;
  logic        erase;
  logic [15:0] mag;
  logic [15:0] cur;
  logic [16:0] cnt;
  logic [15:0] fillStart;
  logic [16:0] fillCnt;
  logic [15:0] colL;
  logic [15:0] colR;
  logic [15:0] dataLeft;
  logic [7:0]  fontCode;
  logic [3:0]  fontLine;
  logic [7:0]  initCode;
  logic [3:0]  initLine;
  logic        initWr;
  logic [10:0] initIdx;
  logic        initPend;
  logic [10:0] initIdxPend;
  logic [7:0]  fontRam [0:`DOCU_FONT_BYTES-1];

  function automatic logic [10:0] fontIndex(input logic [7:0] c,
                                            input logic [3:0] l);
    logic [7:0] rel;
    rel = c - `DOCU_FONT_FIRST;
    return 11'(rel) * 11'(`DOCU_GLYPH_H) + 11'(l);
  endfunction

  // Bus decode.
  // Busy also covers the two trailing ROM copy writes.
  wire        busy    = state != docu_pkg::ST_IDLE || initPend || initWr;
  wire [7:0]  off     = paddr[7:0];
  wire        fontHit = paddr >= `DOCU_FONT_BASE && paddr <= `DOCU_FONT_END;
  wire        regHit  = paddr[15:8] == `DOCU_PAGE && off[1:0] == 2'h0 &&
                        off <= `DOCU_FDATA;
  wire        setup   = psel && !penable;
  wire        wrEn    = psel && penable && pready && pwrite;
  wire        regWr   = wrEn && regHit;
  wire        fontWr  = wrEn && fontHit;
  wire [10:0] winIdx  = {1'b0, paddr[9:2], 2'h0};
  wire        cmdWr   = regWr && off == `DOCU_CMD && !busy;
  wire        goScr   = cmdWr && pwdata[2:0] == docu_pkg::DOCU_SCROLL;
  wire        goSave  = cmdWr && pwdata[2:0] == docu_pkg::DOCU_SAVE;
  wire        goRest  = cmdWr && pwdata[2:0] == docu_pkg::DOCU_RESTORE;
  wire        goFont  = cmdWr && pwdata[2:0] == docu_pkg::DOCU_FONTRST;
  wire        saveOk  = goSave && depth != `DOCU_DEPTH_MAX;
  wire        restOk  = goRest && depth != 3'h0;
  wire        illegal = (goSave && !saveOk) || (goRest && !restOk);
  wire        envWr   = regWr && !busy;
  wire        dataWr  = regWr && off == `DOCU_DATA;
  wire        fdataWr = regWr && off == `DOCU_FDATA;
  wire        codeOk  = fontCode >= `DOCU_FONT_FIRST &&
                        fontCode <= `DOCU_FONT_LASTC &&
                        fontLine <= `DOCU_GLYPH_LAST;
  wire docu_pkg::docu_env_t topEnv = stack[depth - 3'h1];

  // Window placement in the selected address mode.
  wire docu_pkg::docu_pt_t disp =
    env.ixMode == `DOCU_IX_OFF1 ? env.off1 :
    env.ixMode == `DOCU_IX_OFF2 ? env.off2 : '0;
  wire [15:0] top    = env.winTl.y + disp.y;
  wire [15:0] bot    = env.winBr.y + disp.y;
  wire [15:0] magW   = env.shift[15] ? 16'(-env.shift) : env.shift;
  wire [16:0] height = {1'b0, bot} - {1'b0, top} + 17'h1;
  wire        eraseW = {1'b0, magW} > height;
  wire [16:0] copyN  = eraseW ? 17'h0 : height - {1'b0, magW};
  wire [16:0] fillN  = eraseW ? height :
                       env.fillInh ? 17'h0 : {1'b0, magW};
  wire [15:0] fillSt = (eraseW || !env.shift[15]) ? top :
                       bot - magW + 16'h1;
  wire docu_pkg::docu_state_t firstSt =
    env.shift == 16'h0 ? docu_pkg::ST_IDLE :
    copyN != 17'h0 ? docu_pkg::ST_COPY :
    fillN != 17'h0 ? docu_pkg::ST_FILL : docu_pkg::ST_IDLE;

  // Next line operation. Copies walk against the move so no source
  // line is overwritten before it has been read.
  wire        inCopy  = state == docu_pkg::ST_COPY;
  wire [15:0] srcLine = down ? cur - mag : cur + mag;
  wire docu_pkg::docu_mem_t nextOp = '{
    fill:     !inCopy,
    src:      inCopy ? srcLine : cur,
    dst:      cur,
    colFirst: colL,
    colLast:  colR,
    planes:   env.planes,
    value:    env.fillSel ? env.fg : env.bg
  };
  wire [15:0] stepLine = (inCopy && down) ? cur - 16'h1 : cur + 16'h1;
  wire        opDone   = memReq && memAck;
  wire        lastOp   = cnt == 17'h1;

  // Read selection.
  wire [31:0] statWord = {dataLeft, 11'h0, illSticky, depth, busy};
  wire [31:0] fontWord = {fontRam[winIdx + 11'h3], fontRam[winIdx + 11'h2],
                          fontRam[winIdx + 11'h1], fontRam[winIdx]};
  wire [31:0] rdWord =
    fontHit ? fontWord :
    !regHit ? 32'h0 :
    off == `DOCU_CTRL ? {27'h0, env.dataFollows, env.ixMode, env.fillInh,
                         env.fillSel} :
    off == `DOCU_PLANES ? {20'h0, env.planes} :
    off == `DOCU_COLOR ? {4'h0, env.bg, 4'h0, env.fg} :
    off == `DOCU_OFF1 ? env.off1 :
    off == `DOCU_OFF2 ? env.off2 :
    off == `DOCU_WINTL ? env.winTl :
    off == `DOCU_WINBR ? env.winBr :
    off == `DOCU_SHIFT ? {16'h0, env.shift} :
    off == `DOCU_COP ? env.current_operating_point :
    off == `DOCU_STAT ? statWord :
    off == `DOCU_DIMS ? `DOCU_DIMS_VAL :
    off == `DOCU_FCODE ? {24'h0, fontCode} : 32'h0;

  // Zero wait state: the answer is prepared during the setup cycle.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !regHit && !fontHit;
      prdata  <= setup && !pwrite ? rdWord : 32'h0;
    end
  end

  // Environment, stack and events. Parameters are frozen while a
  // scroll runs so every line operation sees the same settings.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      env          <= '0;
      depth        <= 3'h0;
      illSticky    <= 1'b0;
      illegalInstr <= 1'b0;
      dataLeft     <= 16'h0;
      fontCode     <= 8'h0;
      fontLine     <= 4'h0;
    end else begin
      illegalInstr <= illegal;
      illSticky    <= illegal || (illSticky && !(regWr && off == `DOCU_STAT
                      && pwdata[`DOCU_ST_ILL]));
      if (saveOk) begin
        stack[depth] <= env;
        depth        <= depth + 3'h1;
      end
      if (restOk) begin
        env   <= topEnv;
        depth <= depth - 3'h1;
      end
      if (envWr) begin
        unique case (off)
          `DOCU_CTRL: begin
            env.fillSel     <= pwdata[0];
            env.fillInh     <= pwdata[1];
            env.ixMode      <= pwdata[3:2];
            env.dataFollows <= pwdata[4];
          end
          `DOCU_PLANES: env.planes <= pwdata[11:0];
          `DOCU_COLOR: begin
            env.fg <= pwdata[11:0];
            env.bg <= pwdata[27:16];
          end
          `DOCU_OFF1:  env.off1  <= pwdata;
          `DOCU_OFF2:  env.off2  <= pwdata;
          `DOCU_WINTL: env.winTl <= pwdata;
          `DOCU_WINBR: env.winBr <= pwdata;
          `DOCU_SHIFT: env.shift <= pwdata[15:0];
          `DOCU_COP:   env.current_operating_point   <= pwdata;
          default: ;
        endcase
      end
      if (goScr) begin
        dataLeft <= env.dataFollows ? pwdata[31:16] : 16'h0;
      end else if (regWr && off == `DOCU_DLEN) begin
        dataLeft <= pwdata[15:0];
      end else if (dataWr && dataLeft != 16'h0) begin
        dataLeft <= dataLeft - 16'h1;
      end
      if (regWr && off == `DOCU_FCODE) begin
        fontCode <= pwdata[7:0];
        fontLine <= 4'h0;
      end else if (fdataWr && fontLine != `DOCU_GLYPH_H) begin
        fontLine <= fontLine + 4'h1;
      end
    end
  end

  // Scroll and font copy sequencer. The current operating point is
  // never touched here. No line buffer is kept, so partial scaled or
  // filtered lines are not carried across a save and restore.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state     <= docu_pkg::ST_INIT;
      memReq    <= 1'b0;
      memOp     <= '0;
      down      <= 1'b0;
      erase     <= 1'b0;
      mag       <= 16'h0;
      cur       <= 16'h0;
      cnt       <= 17'h0;
      fillStart <= 16'h0;
      fillCnt   <= 17'h0;
      colL      <= 16'h0;
      colR      <= 16'h0;
      initCode  <= `DOCU_FONT_FIRST;
      initLine  <= 4'h0;
      initWr    <= 1'b0;
      initIdx   <= 11'h0;
      initPend  <= 1'b0;
      initIdxPend <= 11'h0;
      promAddr  <= 11'h0;
    end else begin
      // The ROM answers a cycle after its address, so the write index
      // and strobe trail the address by one stage.
      initPend <= state == docu_pkg::ST_INIT;
      initWr   <= initPend;
      initIdx  <= initIdxPend;
      unique case (state)
        docu_pkg::ST_IDLE: begin
          if (goScr) begin
            state     <= firstSt;
            down      <= !env.shift[15];
            erase     <= eraseW;
            mag       <= magW;
            cur       <= env.shift[15] ? top : bot;
            cnt       <= copyN != 17'h0 ? copyN : fillN;
            fillStart <= fillSt;
            fillCnt   <= fillN;
            colL      <= env.winTl.x + disp.x;
            colR      <= env.winBr.x + disp.x;
            if (copyN == 17'h0) begin
              cur <= fillSt;
            end
          end else if (goFont) begin
            state    <= docu_pkg::ST_INIT;
            initCode <= `DOCU_FONT_FIRST;
            initLine <= 4'h0;
          end
        end
        docu_pkg::ST_COPY, docu_pkg::ST_FILL: begin
          if (!memReq) begin
            memReq <= 1'b1;
            memOp  <= nextOp;
          end else if (memAck) begin
            memReq <= 1'b0;
            cnt    <= cnt - 17'h1;
            cur    <= stepLine;
            if (lastOp && inCopy && fillCnt != 17'h0) begin
              state <= docu_pkg::ST_FILL;
              cur   <= fillStart;
              cnt   <= fillCnt;
            end else if (lastOp) begin
              state <= docu_pkg::ST_IDLE;
            end
          end
        end
        docu_pkg::ST_INIT: begin
          promAddr <= {initCode[6:0], initLine};
          initIdxPend <= fontIndex(initCode, initLine);
          if (initLine == `DOCU_GLYPH_LAST) begin
            initLine <= 4'h0;
            initCode <= initCode + 8'h1;
            if (initCode == `DOCU_INIT_LASTC) begin
              state <= docu_pkg::ST_IDLE;
            end
          end else begin
            initLine <= initLine + 4'h1;
          end
        end
      endcase
    end
  end

  // Glyph store: 128 codes of 12 rows of 8 pixels, never reset, so
  // codes above the ROM set keep what was loaded.
  always_ff @(posedge sys_clk) begin
    if (initWr) begin
      fontRam[initIdx] <= promData;
    end else if (fontWr) begin
      for (int k = 0; k < 4; k++) begin
        if (pstrb[k]) begin
          fontRam[winIdx + 11'(k)] <= pwdata[8*k +: 8];
        end
      end
    end else if (fdataWr && codeOk) begin
      fontRam[fontIndex(fontCode, fontLine)] <= pwdata[7:0];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_zero_shift_idle: assert property (
    goScr && env.shift == 16'h0 |=> state == docu_pkg::ST_IDLE && !memReq
  ) else $error("zero shift started a scroll");
  a_full_save_refused: assert property (
    goSave && depth == `DOCU_DEPTH_MAX |=> depth == `DOCU_DEPTH_MAX
      && illegalInstr ##1 illSticky
  ) else $error("save on full stack not refused");
  a_empty_restore_kept: assert property (
    goRest && depth == 3'h0 |=> depth == 3'h0 && illegalInstr && $stable(env)
  ) else $error("restore on empty stack changed state");
  a_save_pushes: assert property (
    saveOk |=> depth == $past(depth) + 3'h1
  ) else $error("save did not push");
  a_restore_pops: assert property (
    restOk |=> env == $past(topEnv) && depth == $past(depth) - 3'h1
  ) else $error("restore did not reload newest entry");
  a_copy_direction: assert property (
    memReq && !memOp.fill |-> (down ? memOp.dst == memOp.src + mag
                                    : memOp.src == memOp.dst + mag)
  ) else $error("copy moves the wrong way");
  a_fill_source: assert property (
    memReq && memOp.fill |-> memOp.planes == env.planes &&
      memOp.value == (env.fillSel ? env.fg : env.bg)
  ) else $error("fill uses wrong value or planes");
  a_inhibit_no_fill: assert property (
    memReq && memOp.fill |-> !env.fillInh || erase
  ) else $error("fill written while inhibited");
  a_cop_held: assert property (
    busy |=> $stable(env.current_operating_point)
  ) else $error("operating point moved during scroll");
  a_data_dropped: assert property (
    dataWr && dataLeft != 16'h0 && !goScr |=> dataLeft == $past(dataLeft) - 1
  ) else $error("trailing data not consumed");
  c_scroll_down: cover property (
    inCopy && down ##[1:200] state == docu_pkg::ST_FILL);
  c_erase: cover property (goScr && eraseW);
  c_illegal: cover property (illegalInstr);
  c_init_done: cover property (
    state == docu_pkg::ST_INIT ##1 state == docu_pkg::ST_IDLE);
endmodule

//--- hw/docu_map.svh
`ifndef DOCU_MAP_SVH
`define DOCU_MAP_SVH
// Register word offsets within the low page.
`define DOCU_CMD        8'h00
`define DOCU_CTRL       8'h04
`define DOCU_PLANES     8'h08
`define DOCU_COLOR      8'h0C
`define DOCU_OFF1       8'h10
`define DOCU_OFF2       8'h14
`define DOCU_WINTL      8'h18
`define DOCU_WINBR      8'h1C
`define DOCU_SHIFT      8'h20
`define DOCU_COP        8'h24
`define DOCU_DLEN       8'h28
`define DOCU_DATA       8'h2C
`define DOCU_STAT       8'h30
`define DOCU_DIMS       8'h34
`define DOCU_FCODE      8'h38
`define DOCU_FDATA      8'h3C
`define DOCU_PAGE       8'h00
// Font window and glyph geometry.
`define DOCU_FONT_BASE  16'h4400
`define DOCU_FONT_END   16'h47FF
`define DOCU_FONT_FIRST 8'h20
`define DOCU_FONT_LASTC 8'h9F
`define DOCU_INIT_LASTC 8'h5F
`define DOCU_GLYPH_H    4'hC
`define DOCU_GLYPH_LAST 4'hB
`define DOCU_FONT_BYTES 1536
// Fixed character cell report: dimension 7 by 9.
`define DOCU_DIMS_VAL   32'h0007_0009
`define DOCU_DEPTH_MAX  3'h5
`define DOCU_ST_ILL     4
`define DOCU_IX_OFF1    2'h1
`define DOCU_IX_OFF2    2'h2
`endif

//--- hw/docu_pkg.sv
package docu_pkg;
  typedef enum logic [2:0] {
    DOCU_NONE    = 3'h0,
    DOCU_SCROLL  = 3'h1,
    DOCU_SAVE    = 3'h2,
    DOCU_RESTORE = 3'h3,
    DOCU_FONTRST = 3'h4
  } docu_cmd_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_COPY = 2'h1,
    ST_FILL = 2'h2,
    ST_INIT = 2'h3
  } docu_state_t;
  typedef struct packed {
    logic [15:0] y;
    logic [15:0] x;
  } docu_pt_t;
  typedef struct packed {
    logic        fillSel;
    logic        fillInh;
    logic [1:0]  ixMode;
    logic        dataFollows;
    logic [11:0] planes;
    logic [11:0] fg;
    logic [11:0] bg;
    docu_pt_t    off1;
    docu_pt_t    off2;
    docu_pt_t    winTl;
    docu_pt_t    winBr;
    docu_pt_t    current_operating_point;
    logic [15:0] shift;
  } docu_env_t;
  typedef struct packed {
    logic        fill;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] colFirst;
    logic [15:0] colLast;
    logic [11:0] planes;
    logic [11:0] value;
  } docu_mem_t;
endpackage

//--- testbench/docu_mem_model.sv
`timescale 1ns/1ns
module docu_mem_model (
  // Clock and log control.
  input  wire logic           sys_clk,
  input  wire logic           clr,
  // Refresh memory line operations.
  input  wire logic           memReq,
  input  docu_pkg::docu_mem_t memOp,
  output logic                memAck,
  // Font ROM.
  input  wire logic [10:0]    promAddr,
  output logic      [7:0]     promData,
  // Log of completed operations.
  output int                  nCopy,
  output int                  nFill,
  output docu_pkg::docu_mem_t firstCopy,
  output docu_pkg::docu_mem_t firstFill,
  output logic      [11:0]    planesSeen
);
  logic [1:0] wt;
  logic       slow;
  // Prompt and slow answers alternate so both paths see traffic.
  always_ff @(posedge sys_clk) begin
    if (clr || !memReq || memAck) begin
      wt <= 2'h0;
      memAck <= 1'b0;
    end else begin
      wt <= wt + 2'h1;
      memAck <= (wt >= (slow ? 2'h3 : 2'h0));
    end
  end
  always_ff @(posedge sys_clk) begin
    promData <= promAddr[7:0] ^ 8'hA5;
    if (clr) begin
      slow <= 1'b0;
      nCopy <= 0;
      nFill <= 0;
      firstCopy <= '0;
      firstFill <= '0;
      planesSeen <= 12'h000;
    end else if (memReq && memAck) begin
      slow <= !slow;
      planesSeen <= planesSeen | memOp.planes;
      if (memOp.fill) begin
        if (nFill == 0) firstFill <= memOp;
        nFill <= nFill + 1;
      end else begin
        if (nCopy == 0) firstCopy <= memOp;
        nCopy <= nCopy + 1;
      end
    end
  end
endmodule

//--- testbench/test_display_option_command_unit.sv
`timescale 1ns/1ns
`include "docu_map.svh"
module test_display_option_command_unit;
  typedef struct packed {
    logic [15:0] ctrl, shift, off2, nCp, nFl, cpDst, cpSrc, flDst, val;
  } docu_row_t;
  logic                sys_clk = 1'b0;
  logic                srst, psel, penable, pwrite, clr;
  logic [15:0]         paddr;
  logic [31:0]         pwdata, prdata, rdat, cols;
  logic [3:0]          pstrb;
  logic                pready, pslverr, memReq, memAck, illegalInstr, err;
  docu_pkg::docu_mem_t memOp, firstCopy, firstFill;
  logic [10:0]         promAddr;
  logic [7:0]          promData;
  logic [11:0]         planesSeen;
  int                  nCopy, nFill, nIll = 0;
  int                  miscompares = 0;
  int                  checks = 0;
  docu_row_t           r;
  docu_row_t           rows [10] = '{
    '{16'h0, 16'h2, 16'h0, 16'h8, 16'h2, 16'h13, 16'h11, 16'hA, 16'hABC},
    '{16'h0, 16'hFFFE, 16'h0, 16'h8, 16'h2, 16'hA, 16'hC, 16'h12, 16'hABC},
    '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0},
    '{16'h2, 16'h3, 16'h0, 16'h7, 16'h0, 16'h13, 16'h10, 16'h0, 16'h0},
    '{16'h1, 16'h14, 16'h0, 16'h0, 16'hA, 16'h0, 16'h0, 16'hA, 16'h123},
    '{16'h3, 16'hA, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0},
    '{16'h4, 16'h1, 16'h0, 16'h9, 16'h1, 16'h18, 16'h17, 16'hF, 16'hABC},
    '{16'h8, 16'h1, 16'h7, 16'h9, 16'h1, 16'h1A, 16'h19, 16'h11, 16'hABC},
    '{16'hC, 16'h1, 16'h7, 16'h9, 16'h1, 16'h13, 16'h12, 16'hA, 16'hABC},
    '{16'h0, 16'hFFEC, 16'h0, 16'h0, 16'hA, 16'h0, 16'h0, 16'hA, 16'hABC}
  };

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (illegalInstr === 1'b1) nIll <= nIll + 1;
  end

  docu_top dut (.sys_clk, .srst, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .memReq, .memOp,
    .memAck, .promAddr, .promData, .illegalInstr);
  docu_mem_model far (.sys_clk, .clr, .memReq, .memOp, .memAck,
    .promAddr, .promData, .nCopy, .nFill, .firstCopy, .firstFill,
    .planesSeen);

  task automatic end_of_test();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One transfer, then an idle cycle so psel never changes twice at once.
  task automatic apb(input logic [15:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    if (n == 50) begin
      miscompares++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic waitIdle();
    for (int i = 0; i < 1000; i++) begin
      apb(`DOCU_STAT, 1'b0, 32'h0);
      if (rdat[0] === 1'b0) return;
    end
    miscompares++;
    end_of_test();
  endtask
  task automatic cmd(input logic [31:0] c);
    wr(`DOCU_CMD, c);
    waitIdle();
  endtask

  initial begin
    srst = 1'b1;
    {psel, penable, pwrite, clr} = 4'h1;
    paddr = 16'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    repeat (3) @(posedge sys_clk);
    chk({28'h0, pready, pslverr, memReq, illegalInstr}, 32'h0);
    srst <= 1'b0;
    clr <= 1'b0;
    @(posedge sys_clk);
    apb(`DOCU_STAT, 1'b0, 32'h0);
    chk({31'h0, rdat[0]}, 32'h1);
    waitIdle();
    rd(16'h4400, 32'hA6A7A4A5);
    rd(`DOCU_DIMS, `DOCU_DIMS_VAL);
    rd(16'h0040, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(`DOCU_PLANES, 32'h0F0);
    wr(`DOCU_COLOR, 32'h0ABC_0123);
    wr(`DOCU_WINTL, 32'h000A_0000);
    wr(`DOCU_WINBR, 32'h0013_0007);
    wr(`DOCU_OFF1, 32'h0005_0002);
    wr(`DOCU_COP, 32'h0033_0044);
    foreach (rows[i]) begin
      r = rows[i];
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      wr(`DOCU_OFF2, {r.off2, 16'h0});
      wr(`DOCU_CTRL, {16'h0, r.ctrl});
      wr(`DOCU_SHIFT, {16'h0, r.shift});
      cmd(32'h1);
      chk(nCopy, {16'h0, r.nCp});
      chk(nFill, {16'h0, r.nFl});
      chk({16'h0, firstCopy.dst}, {16'h0, r.cpDst});
      chk({16'h0, firstCopy.src}, {16'h0, r.cpSrc});
      chk({16'h0, firstFill.dst}, {16'h0, r.flDst});
      chk({20'h0, firstFill.value}, {16'h0, r.val});
      chk({20'h0, planesSeen}, (r.nCp | r.nFl) != 0 ? 32'h0F0 : 32'h0);
      cols = r.ctrl[3:2] == 2'h1 ? 32'h0002_0009 : 32'h0000_0007;
      if (r.nFl == 16'h0) cols = 32'h0;
      chk({firstFill.colFirst, firstFill.colLast}, cols);
    end
    rd(`DOCU_COP, 32'h0033_0044);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    wr(`DOCU_CTRL, 32'h10);
    wr(`DOCU_SHIFT, 32'h0);
    cmd(32'h0002_0001);
    chk({16'h0, rdat[31:16]}, 32'h2);
    wr(`DOCU_DATA, 32'h0);
    wr(`DOCU_DATA, 32'h0);
    waitIdle();
    chk({16'h0, rdat[31:16]}, 32'h0);
    chk(nCopy + nFill, 32'h0);
    wr(`DOCU_DLEN, 32'h3);
    wr(`DOCU_DATA, 32'h0);
    waitIdle();
    chk({16'h0, rdat[31:16]}, 32'h2);
    for (int i = 0; i < 6; i++) begin
      wr(`DOCU_COP, 32'(i));
      cmd(32'h2);
    end
    chk(nIll, 32'h1);
    chk({29'h0, rdat[3:1]}, {29'h0, `DOCU_DEPTH_MAX});
    wr(`DOCU_COP, 32'h99);
    cmd(32'h3);
    rd(`DOCU_COP, 32'h4);
    repeat (4) cmd(32'h3);
    rd(`DOCU_COP, 32'h0);
    wr(`DOCU_COP, 32'h77);
    cmd(32'h3);
    chk(nIll, 32'h2);
    chk({31'h0, rdat[4]}, 32'h1);
    rd(`DOCU_COP, 32'h77);
    wr(`DOCU_STAT, 32'h10);
    waitIdle();
    chk({31'h0, rdat[4]}, 32'h0);
    wr(`DOCU_FCODE, 32'h60);
    for (int i = 0; i < 4; i++) wr(`DOCU_FDATA, 32'h3C + 32'(i));
    wr(`DOCU_FCODE, 32'h21);
    for (int i = 0; i < 13; i++) wr(`DOCU_FDATA, 32'hE0 + 32'(i));
    rd(16'h440C, 32'hE3E2E1E0);
    rd(16'h4418, 32'h86878485);
    wr(16'h4410, 32'h44332211);
    rd(16'h4410, 32'h44332211);
    pstrb <= 4'h2;
    wr(16'h4410, 32'h0000_5500);
    pstrb <= 4'hF;
    rd(16'h4410, 32'h4433_5511);
    wr(`DOCU_FCODE, 32'hA0);
    wr(`DOCU_FDATA, 32'hFF);
    rd(16'h4400, 32'hA6A7A4A5);
    wr(16'h47F4, 32'h5A5A_5A5A);
    wr(`DOCU_FCODE, 32'h1F);
    wr(`DOCU_FDATA, 32'hFF);
    rd(16'h47F4, 32'h5A5A_5A5A);
    cmd(32'h4);
    rd(16'h4700, 32'h3F3E3D3C);
    wr(`DOCU_SHIFT, 32'h2);
    wr(`DOCU_CMD, 32'h1);
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({31'h0, memReq}, 32'h0);
    srst <= 1'b0;
    @(posedge sys_clk);
    waitIdle();
    rd(16'h4700, 32'h3F3E3D3C);
    rd(16'h4400, 32'hA6A7A4A5);
    end_of_test();
  end
endmodule
